/* File: rtl/dfp_top.v */
// Drive fault protection: coast stop, fan, overload limits, trip log
// Summary of operation
// - Mode 0: coast immediately, delay ignored
// - Mode 1: coast after configured delay, max 60s
// - No delayed coast during speed search
// - Mode applies only to terminal coast requests
// - Fan mode 0: run when heatsink hot
// - Fan mode 1: run whenever powered
// - Fan mode 2: run, then until cooled
// - Two prealarm coefficients 50-100, default 80
// - Drive overload coefficient 120-190, default 150
// - Motor overload 20-100; smaller trips faster
// - Below 10Hz lower motor overload threshold
// - Keep three newest trip types
// - Trip codes 2 through 8
// - Trip codes 11 through 18
// - Trip codes 20 through 67
// - Snapshot frequency, current, bus voltage per trip
// - Count overcurrent, overvoltage, overheat, overload faults
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dfp_consts.vh"
module dfp_top #(
  parameter DW = 16,
  parameter NW = 16,
  parameter STEP_CYC = `DFP_DELAY_STEP_NS / `DFP_CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  output wire irq,
  input wire term_coast_req,
  input wire other_coast_req,
  input wire speed_search,
  input wire running,
  input wire heatsink_hot,
  input wire [DW-1:0] out_freq,
  input wire [DW-1:0] out_curr,
  input wire [DW-1:0] bus_volt,
  input wire [DW-1:0] rated_curr,
  input wire overcurrent_trip,
  input wire overvoltage_trip,
  input wire input_phase_loss_det,
  input wire supply_undervoltage_trip,
  input wire heatsink_overtemp_det,
  input wire external_fault_trip,
  input wire prerun_current_fault,
  input wire tuning_without_motor_fault,
  input wire current_sampling_fault,
  input wire secondary_overcurrent_trip,
  input wire output_phase_loss_det,
  input wire analog_loss_trip,
  input wire underload_trip,
  input wire pressure_trip,
  input wire pid_setting_fault,
  input wire sync_motor_tuning_fault,
  input wire comm_timeout_trip,
  input wire speed_search_fault,
  input wire watchdog_trip,
  input wire tertiary_overcurrent_trip,
  input wire drive_overload_det,
  input wire motor_overload_det,
  output reg coast_stop,
  output reg fan_on,
  output reg [DW-1:0] drive_ol_limit,
  output reg [DW-1:0] drive_pre_limit,
  output reg [DW-1:0] motor_ol_limit,
  output reg [DW-1:0] motor_pre_limit,
  output reg trip_out
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  reg coast_stop_mode_select;
  reg [9:0] coast_stop_delay;
  reg [1:0] fan_control_select;
  reg [6:0] drive_overload_prealarm_coef;
  reg [6:0] motor_overload_prealarm_coef;
  reg [7:0] drive_overload_coef;
  reg [6:0] motor_overload_coef;
  reg input_phase_loss_enable;
  reg overheat_protect_enable;
  reg output_phase_loss_enable;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] tick_reg;
  reg [9:0] dcnt_reg;
  reg run_seen_reg;
  reg [6:0] trip_code;
  reg trip_valid;
  reg [3:0] irq_evt;
  reg [14:0] mot_eff;
  reg [31:0] rd_mux;
  wire [20:0] code_flat;
  wire [9*DW-1:0] snap_flat;
  wire [4*NW-1:0] count_flat;
  wire tick;
  wire [6:0] wd7;
  wire [7:0] wd8;
  wire [9:0] wd10;

  assign wd7 = wdata[6:0];
  assign wd8 = wdata[7:0];
  assign wd10 = wdata[9:0];
  wire [31:0] dol_c = rated_curr * drive_overload_coef / 32'h0000_0064;
  wire [31:0] dpr_c = dol_c * drive_overload_prealarm_coef / 32'h0000_0064;
  wire [31:0] mol_c = rated_curr * mot_eff / 32'h0000_0064;
  wire [31:0] mpr_c = mol_c * motor_overload_prealarm_coef / 32'h0000_0064;

  // Out-of-range settings are refused, old value kept
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coast_stop_mode_select <= `DFP_RST_COAST_MODE;
      coast_stop_delay <= `DFP_RST_COAST_DELAY;
      fan_control_select <= `DFP_RST_FAN_SEL;
      drive_overload_prealarm_coef <= `DFP_RST_PRE;
      motor_overload_prealarm_coef <= `DFP_RST_PRE;
      drive_overload_coef <= `DFP_RST_DRV_OL;
      motor_overload_coef <= `DFP_RST_MOT_OL;
      input_phase_loss_enable <= 1'b1;
      overheat_protect_enable <= 1'b1;
      output_phase_loss_enable <= 1'b0;
      irq_mask_reg <= 4'h0;
    end else if (wr_en) begin
      case (addr)
        `DFP_A_COAST_MODE: coast_stop_mode_select <= wdata[0];
        `DFP_A_COAST_DELAY:
          if (wdata[31:10] == 22'h0 && wd10 <= `DFP_DELAY_MAX)
            coast_stop_delay <= wd10;
        `DFP_A_FAN_SEL:
          if (wdata[31:2] == 30'h0 && wdata[1:0] != 2'h3)
            fan_control_select <= wdata[1:0];
        `DFP_A_DRV_PRE:
          if (wdata[31:7] == 25'h0 && wd7 >= `DFP_PRE_MIN &&
              wd7 <= `DFP_PRE_MAX)
            drive_overload_prealarm_coef <= wd7;
        `DFP_A_MOT_PRE:
          if (wdata[31:7] == 25'h0 && wd7 >= `DFP_PRE_MIN &&
              wd7 <= `DFP_PRE_MAX)
            motor_overload_prealarm_coef <= wd7;
        `DFP_A_DRV_OL:
          if (wdata[31:8] == 24'h0 && wd8 >= `DFP_DRV_OL_MIN &&
              wd8 <= `DFP_DRV_OL_MAX)
            drive_overload_coef <= wd8;
        `DFP_A_MOT_OL:
          if (wdata[31:7] == 25'h0 && wd7 >= `DFP_MOT_OL_MIN &&
              wd7 <= `DFP_MOT_OL_MAX)
            motor_overload_coef <= wd7;
        `DFP_A_IPL_EN: input_phase_loss_enable <= wdata[0];
        `DFP_A_OH_EN: overheat_protect_enable <= wdata[0];
        `DFP_A_OPL_EN: output_phase_loss_enable <= wdata[0];
        `DFP_A_IRQ_MASK: irq_mask_reg <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // 100 ms tick for the coast delay
  assign tick = tick_reg == STEP_CYC - 1;
  always @(posedge clk or posedge rst) begin
    if (rst)
      tick_reg <= 32'h0000_0000;
    else if (state_reg != ST_WAIT || tick)
      tick_reg <= 32'h0000_0000;
    else
      tick_reg <= tick_reg + 32'h0000_0001;
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (other_coast_req) begin
          state_next = ST_STOP;
        end else if (term_coast_req) begin
          if (!coast_stop_mode_select || speed_search ||
              coast_stop_delay == 10'h000)
            state_next = ST_STOP;
          else
            state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (other_coast_req || (speed_search && term_coast_req))
          state_next = ST_STOP;
        else if (!term_coast_req)
          state_next = ST_IDLE;
        else if (tick && dcnt_reg == coast_stop_delay - 10'h001)
          state_next = ST_STOP;
      end
      ST_STOP: begin
        if (!term_coast_req && !other_coast_req)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      dcnt_reg <= 10'h000;
      coast_stop <= 1'b0;
    end else begin
      state_reg <= state_next;
      coast_stop <= state_next == ST_STOP;
      if (state_reg != ST_WAIT)
        dcnt_reg <= 10'h000;
      else if (tick)
        dcnt_reg <= dcnt_reg + 10'h001;
    end
  end

  // Fan: the run-seen latch holds the fan after a stop until cool
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_seen_reg <= 1'b0;
      fan_on <= 1'b0;
    end else begin
      if (running)
        run_seen_reg <= 1'b1;
      else if (!heatsink_hot)
        run_seen_reg <= 1'b0;
      case (fan_control_select)
        `DFP_FAN_TEMP: fan_on <= heatsink_hot;
        `DFP_FAN_ALWAYS: fan_on <= 1'b1;
        `DFP_FAN_RUN: fan_on <= running ||
          (run_seen_reg && heatsink_hot);
        default: fan_on <= 1'b0;
      endcase
    end
  end

  // Limits in current units; below 10 Hz the motor limit is derated
  always @* begin
    mot_eff = {8'h00, motor_overload_coef};
    if (out_freq < `DFP_LOWF_LIMIT)
      mot_eff = motor_overload_coef * `DFP_LOWF_PCT / 15'h0064;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_ol_limit <= {DW{1'b0}};
      drive_pre_limit <= {DW{1'b0}};
      motor_ol_limit <= {DW{1'b0}};
      motor_pre_limit <= {DW{1'b0}};
    end else begin
      drive_ol_limit <= dol_c[DW-1:0];
      drive_pre_limit <= dpr_c[DW-1:0];
      motor_ol_limit <= mol_c[DW-1:0];
      motor_pre_limit <= mpr_c[DW-1:0];
    end
  end

  // Fault priority encoder; one code logged per cycle
  always @* begin
    trip_valid = 1'b1;
    if (overcurrent_trip) trip_code = `DFP_TC_OVERCURRENT;
    else if (overvoltage_trip) trip_code = `DFP_TC_OVERVOLTAGE;
    else if (input_phase_loss_det && input_phase_loss_enable)
      trip_code = `DFP_TC_IN_PHASE;
    else if (drive_overload_det) trip_code = `DFP_TC_DRV_OL;
    else if (supply_undervoltage_trip) trip_code = `DFP_TC_UNDERVOLT;
    else if (heatsink_overtemp_det && overheat_protect_enable)
      trip_code = `DFP_TC_OVERHEAT;
    else if (motor_overload_det) trip_code = `DFP_TC_MOT_OL;
    else if (external_fault_trip) trip_code = `DFP_TC_EXTERNAL;
    else if (prerun_current_fault) trip_code = `DFP_TC_PRERUN;
    else if (tuning_without_motor_fault) trip_code = `DFP_TC_NO_MOTOR;
    else if (current_sampling_fault) trip_code = `DFP_TC_SAMPLING;
    else if (secondary_overcurrent_trip) trip_code = `DFP_TC_OC_SEC;
    else if (output_phase_loss_det && output_phase_loss_enable)
      trip_code = `DFP_TC_OUT_PHASE;
    else if (analog_loss_trip) trip_code = `DFP_TC_ANALOG;
    else if (underload_trip) trip_code = `DFP_TC_UNDERLOAD;
    else if (pressure_trip) trip_code = `DFP_TC_PRESSURE;
    else if (pid_setting_fault) trip_code = `DFP_TC_PID;
    else if (sync_motor_tuning_fault) trip_code = `DFP_TC_SYNC_TUNE;
    else if (comm_timeout_trip) trip_code = `DFP_TC_COMM;
    else if (speed_search_fault) trip_code = `DFP_TC_SEARCH;
    else if (watchdog_trip) trip_code = `DFP_TC_WATCHDOG;
    else if (tertiary_overcurrent_trip) trip_code = `DFP_TC_OC_TER;
    else begin
      trip_code = 7'h00;
      trip_valid = 1'b0;
    end
  end

  // Trip output follows any enabled fault one cycle later; only its rising edge logs, so a held fault logs once
  always @(posedge clk or posedge rst) begin
    if (rst)
      trip_out <= 1'b0;
    else
      trip_out <= trip_valid;
  end

  dfp_trip_log #(.CW(7), .DW(DW), .NW(NW)) u_log (
    .clk(clk),
    .rst(rst),
    .trip_valid(trip_valid && !trip_out),
    .trip_code(trip_code),
    .freq_in(out_freq),
    .curr_in(out_curr),
    .vbus_in(bus_volt),
    .code_flat(code_flat),
    .snap_flat(snap_flat),
    .count_flat(count_flat)
  );

  // Sticky interrupts, write one to clear, set wins
  always @* begin
    irq_evt = 4'h0;
    irq_evt[`DFP_IRQ_TRIP] = trip_valid && !trip_out;
    irq_evt[`DFP_IRQ_COAST] = state_next == ST_STOP && !coast_stop;
    irq_evt[`DFP_IRQ_DRV_PRE] = out_curr >= dpr_c[DW-1:0];
    irq_evt[`DFP_IRQ_MOT_PRE] = out_curr >= mpr_c[DW-1:0];
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      irq_stat_reg <= 4'h0;
    else if (wr_en && addr == `DFP_A_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~wdata[3:0]) | irq_evt;
    else
      irq_stat_reg <= irq_stat_reg | irq_evt;
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `DFP_A_COAST_MODE: rd_mux[0] = coast_stop_mode_select;
      `DFP_A_COAST_DELAY: rd_mux[9:0] = coast_stop_delay;
      `DFP_A_FAN_SEL: rd_mux[1:0] = fan_control_select;
      `DFP_A_DRV_PRE: rd_mux[6:0] = drive_overload_prealarm_coef;
      `DFP_A_MOT_PRE: rd_mux[6:0] = motor_overload_prealarm_coef;
      `DFP_A_DRV_OL: rd_mux[7:0] = drive_overload_coef;
      `DFP_A_MOT_OL: rd_mux[6:0] = motor_overload_coef;
      `DFP_A_TRIP0: rd_mux[6:0] = code_flat[6:0];
      `DFP_A_TRIP1: rd_mux[6:0] = code_flat[13:7];
      `DFP_A_TRIP2: rd_mux[6:0] = code_flat[20:14];
      `DFP_A_IPL_EN: rd_mux[0] = input_phase_loss_enable;
      `DFP_A_OH_EN: rd_mux[0] = overheat_protect_enable;
      `DFP_A_OPL_EN: rd_mux[0] = output_phase_loss_enable;
      `DFP_A_IRQ_STAT: rd_mux[3:0] = irq_stat_reg;
      `DFP_A_IRQ_MASK: rd_mux[3:0] = irq_mask_reg;
      `DFP_A_STATUS: rd_mux[5:0] = {trip_out, fan_on, coast_stop, state_reg};
      default: begin
        if (addr >= `DFP_A_REC0 && addr < `DFP_A_REC0 + 8'h09)
          rd_mux[DW-1:0] = snap_flat[(addr - `DFP_A_REC0) * DW +: DW];
        else if (addr >= `DFP_A_CNT_OC && addr <= `DFP_A_CNT_OL)
          rd_mux[NW-1:0] = count_flat[(addr - `DFP_A_CNT_OC) * NW +: NW];
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd_en)
      rdata <= rd_mux;
    else
      rdata <= 32'h0000_0000;
  end
endmodule

/* File: pkg/dfp_consts.vh */
// Constants for the drive fault protection block
`ifndef DFP_CONSTS_VH
`define DFP_CONSTS_VH

// Register offsets
`define DFP_A_COAST_MODE 8'h00
`define DFP_A_COAST_DELAY 8'h01
`define DFP_A_FAN_SEL 8'h02
`define DFP_A_DRV_PRE 8'h04
`define DFP_A_MOT_PRE 8'h05
`define DFP_A_DRV_OL 8'h06
`define DFP_A_MOT_OL 8'h07
`define DFP_A_TRIP0 8'h08
`define DFP_A_TRIP1 8'h09
`define DFP_A_TRIP2 8'h0A
`define DFP_A_REC0 8'h0B
`define DFP_A_CNT_OC 8'h14
`define DFP_A_CNT_OV 8'h15
`define DFP_A_CNT_OH 8'h16
`define DFP_A_CNT_OL 8'h17
`define DFP_A_IPL_EN 8'h18
`define DFP_A_OH_EN 8'h1A
`define DFP_A_OPL_EN 8'h1B
`define DFP_A_IRQ_STAT 8'h20
`define DFP_A_IRQ_MASK 8'h21
`define DFP_A_STATUS 8'h22

// Reset values
`define DFP_RST_COAST_MODE 1'b0
`define DFP_RST_COAST_DELAY 10'h000
`define DFP_RST_FAN_SEL 2'h2
`define DFP_RST_PRE 7'h50
`define DFP_RST_DRV_OL 8'h96
`define DFP_RST_MOT_OL 7'h64

// Setting ranges
`define DFP_PRE_MIN 7'h32
`define DFP_PRE_MAX 7'h64
`define DFP_DRV_OL_MIN 8'h78
`define DFP_DRV_OL_MAX 8'hBE
`define DFP_MOT_OL_MIN 7'h14
`define DFP_MOT_OL_MAX 7'h64
`define DFP_DELAY_MAX 10'h258

// Fan modes
`define DFP_FAN_TEMP 2'h0
`define DFP_FAN_ALWAYS 2'h1
`define DFP_FAN_RUN 2'h2

// Trip codes
`define DFP_TC_OVERCURRENT 7'h02
`define DFP_TC_OVERVOLTAGE 7'h03
`define DFP_TC_IN_PHASE 7'h04
`define DFP_TC_DRV_OL 7'h05
`define DFP_TC_UNDERVOLT 7'h06
`define DFP_TC_OVERHEAT 7'h07
`define DFP_TC_MOT_OL 7'h08
`define DFP_TC_EXTERNAL 7'h0B
`define DFP_TC_PRERUN 7'h0C
`define DFP_TC_NO_MOTOR 7'h0D
`define DFP_TC_SAMPLING 7'h0F
`define DFP_TC_OC_SEC 7'h10
`define DFP_TC_OUT_PHASE 7'h11
`define DFP_TC_ANALOG 7'h12
`define DFP_TC_UNDERLOAD 7'h14
`define DFP_TC_PRESSURE 7'h16
`define DFP_TC_PID 7'h17
`define DFP_TC_SYNC_TUNE 7'h20
`define DFP_TC_COMM 7'h2D
`define DFP_TC_SEARCH 7'h2E
`define DFP_TC_WATCHDOG 7'h31
`define DFP_TC_OC_TER 7'h43

// Timing: delay step 100 ms, clock 100 ns
`define DFP_DELAY_STEP_NS 100000000
`define DFP_CLK_NS 100
// Low-speed derating: 10 Hz in 0.01 Hz units, 80 percent of threshold
`define DFP_LOWF_LIMIT 16'h03E8
`define DFP_LOWF_PCT 8'h50

// Interrupt bits
`define DFP_IRQ_TRIP 0
`define DFP_IRQ_COAST 1
`define DFP_IRQ_DRV_PRE 2
`define DFP_IRQ_MOT_PRE 3

`endif

/* File: rtl/dfp_trip_log.v */
// Three-deep trip history with snapshots and category counters
`timescale 1ns/1ps
module dfp_trip_log #(
  parameter CW = 7,
  parameter DW = 16,
  parameter NW = 16
) (
  input wire clk,
  input wire rst,
  input wire trip_valid,
  input wire [CW-1:0] trip_code,
  input wire [DW-1:0] freq_in,
  input wire [DW-1:0] curr_in,
  input wire [DW-1:0] vbus_in,
  output wire [3*CW-1:0] code_flat,
  output wire [9*DW-1:0] snap_flat,
  output wire [4*NW-1:0] count_flat
);
  reg [CW-1:0] code_reg [0:2];
  reg [3*DW-1:0] snap_reg [0:2];
  reg [NW-1:0] cnt_reg [0:3];
  wire [3:0] cat_hit;
  genvar i;

  assign cat_hit[0] = trip_code == `DFP_TC_OVERCURRENT ||
    trip_code == `DFP_TC_OC_SEC || trip_code == `DFP_TC_OC_TER;
  assign cat_hit[1] = trip_code == `DFP_TC_OVERVOLTAGE;
  assign cat_hit[2] = trip_code == `DFP_TC_OVERHEAT;
  assign cat_hit[3] = trip_code == `DFP_TC_DRV_OL ||
    trip_code == `DFP_TC_MOT_OL;

  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ent
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          code_reg[i] <= {CW{1'b0}};
          snap_reg[i] <= {3*DW{1'b0}};
        end else if (trip_valid) begin
          if (i == 0) begin
            code_reg[i] <= trip_code;
            snap_reg[i] <= {vbus_in, curr_in, freq_in};
          end else begin
            code_reg[i] <= code_reg[i-1];
            snap_reg[i] <= snap_reg[i-1];
          end
        end
      end
      assign code_flat[i*CW +: CW] = code_reg[i];
      assign snap_flat[i*3*DW +: 3*DW] = snap_reg[i];
    end
    for (i = 0; i < 4; i = i + 1) begin : g_cnt
      // Saturate so a wrapped count never reads as few faults
      always @(posedge clk or posedge rst) begin
        if (rst)
          cnt_reg[i] <= {NW{1'b0}};
        else if (trip_valid && cat_hit[i] && ~&cnt_reg[i])
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
      assign count_flat[i*NW +: NW] = cnt_reg[i];
    end
  endgenerate
endmodule

/* File: tb/dfp_top_assertions.sv */
// Port-level checks for the drive fault protection block
`timescale 1ns/1ps
`include "dfp_consts.vh"
module dfp_top_assertions #(
  parameter DW = 16
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata,
  input wire term_coast_req,
  input wire other_coast_req,
  input wire speed_search,
  input wire running,
  input wire heatsink_hot,
  input wire [DW-1:0] rated_curr,
  input wire overvoltage_trip,
  input wire watchdog_trip,
  input wire coast_stop,
  input wire fan_on,
  input wire [DW-1:0] drive_ol_limit,
  input wire trip_out
);
  reg [1:0] fan_sh;
  reg [7:0] dol_sh;
  wire [31:0] dlim = {{(32-DW){1'b0}}, drive_ol_limit};
  wire [31:0] rated32 = {{(32-DW){1'b0}}, rated_curr};
  // Shadows of two settings; out-of-range writes are dropped like the block
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fan_sh <= `DFP_RST_FAN_SEL;
      dol_sh <= `DFP_RST_DRV_OL;
    end else if (wr_en) begin
      if (addr == `DFP_A_FAN_SEL && wdata < 32'h0000_0003)
        fan_sh <= wdata[1:0];
      if (addr == `DFP_A_DRV_OL && wdata >= 32'h0000_0078 &&
          wdata <= 32'h0000_00BE)
        dol_sh <= wdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence term_search;
    term_coast_req && speed_search;
  endsequence
  sequence all_quiet;
    !term_coast_req && !other_coast_req;
  endsequence
  sequence fan_should_rest;
    (fan_sh == `DFP_FAN_TEMP && !heatsink_hot) ||
    (fan_sh == `DFP_FAN_RUN && !running && !heatsink_hot);
  endsequence
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  chk_coast_release: assert property (all_quiet |=> !coast_stop)
    else $error("coast stop held without request");
  chk_other_immediate: assert property (other_coast_req |=> coast_stop)
    else $error("other coast request not immediate");
  chk_search_coast: assert property (term_search |-> ##[1:2] coast_stop)
    else $error("delayed coast applied during speed search");
  chk_trip_follow: assert property ((overvoltage_trip || watchdog_trip) |=> trip_out)
    else $error("trip output missing after fault");
  chk_fan_always: assert property (fan_sh == `DFP_FAN_ALWAYS |=> fan_on)
    else $error("fan off in always mode");
  chk_fan_hot: assert property (fan_sh == `DFP_FAN_TEMP && heatsink_hot |=> fan_on)
    else $error("fan off while heatsink hot");
  chk_fan_run: assert property (fan_sh == `DFP_FAN_RUN && running |=> fan_on)
    else $error("fan off while running");
  chk_fan_rest: assert property (fan_should_rest |=> !fan_on)
    else $error("fan on while cool and idle");
  chk_drive_limit: assert property (!$past(rst) |->
    dlim == $past(rated32) * $past(dol_sh) / 32'h0000_0064)
    else $error("drive overload limit wrong");
endmodule

/* File: tb/dfp_stage_model.sv */
// Power stage model: fault levels and live measurements
`timescale 1ns/1ps
module dfp_stage_model (
  input wire clk,
  input wire [4:0] fault_idx,
  input wire fault_go,
  input wire [15:0] base_freq,
  output reg [21:0] fault_vec = 22'h00_0000,
  output reg [15:0] freq = 16'h0000,
  output reg [15:0] curr = 16'h0100,
  output reg [15:0] volt = 16'h0200
);
  // Current and voltage follow the fault index so snapshots differ
  always @(posedge clk) begin
    fault_vec <= fault_go ? (22'h00_0001 << fault_idx) : 22'h00_0000;
    freq <= base_freq;
    curr <= 16'h0100 + {11'h000, fault_idx};
    volt <= 16'h0200 + {11'h000, fault_idx};
  end
endmodule

/* File: tb/dfp_top_bench.sv */
// Self-checking bench for the drive fault protection block
`timescale 1ns/1ps
`include "dfp_consts.vh"
module dfp_top_bench;
  localparam [175:0] CODES = {8'h43, 8'h31, 8'h2E, 8'h2D, 8'h20, 8'h17,
    8'h16, 8'h14, 8'h12, 8'h11, 8'h10, 8'h0F, 8'h0D, 8'h0C, 8'h0B, 8'h08,
    8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg term = 1'b0;
  reg other = 1'b0;
  reg search = 1'b0;
  reg running = 1'b0;
  reg hot = 1'b0;
  reg [4:0] fidx = 5'h00;
  reg fgo = 1'b0;
  reg [15:0] bfreq = 16'h1388;
  wire [31:0] rdata;
  wire irq, coast_stop, fan_on, trip_out;
  wire [15:0] dol, dpre, mol, mpre, freq, curr, volt;
  wire [21:0] fv;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  always #50 clk = ~clk;
  dfp_stage_model dfp_stage_model_inst (.clk(clk), .fault_idx(fidx),
    .fault_go(fgo), .base_freq(bfreq), .fault_vec(fv), .freq(freq),
    .curr(curr), .volt(volt));
  dfp_top #(.STEP_CYC(10)) dfp_top_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .term_coast_req(term), .other_coast_req(other), .speed_search(search),
    .running(running), .heatsink_hot(hot), .out_freq(freq),
    .out_curr(curr), .bus_volt(volt), .rated_curr(16'h03E8),
    .overcurrent_trip(fv[0]), .overvoltage_trip(fv[1]),
    .input_phase_loss_det(fv[2]), .drive_overload_det(fv[3]),
    .supply_undervoltage_trip(fv[4]), .heatsink_overtemp_det(fv[5]),
    .motor_overload_det(fv[6]), .external_fault_trip(fv[7]),
    .prerun_current_fault(fv[8]), .tuning_without_motor_fault(fv[9]),
    .current_sampling_fault(fv[10]), .secondary_overcurrent_trip(fv[11]),
    .output_phase_loss_det(fv[12]), .analog_loss_trip(fv[13]),
    .underload_trip(fv[14]), .pressure_trip(fv[15]),
    .pid_setting_fault(fv[16]), .sync_motor_tuning_fault(fv[17]),
    .comm_timeout_trip(fv[18]), .speed_search_fault(fv[19]),
    .watchdog_trip(fv[20]), .tertiary_overcurrent_trip(fv[21]),
    .coast_stop(coast_stop), .fan_on(fan_on), .drive_ol_limit(dol),
    .drive_pre_limit(dpre), .motor_ol_limit(mol), .motor_pre_limit(mpre),
    .trip_out(trip_out));
  task automatic tally_and_finish;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Ceiling sits well above the roughly 450 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string nm, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp("register", e, rdata);
  endtask
  task automatic fault(input int i);
    @(posedge clk);
    fidx <= i[4:0];
    fgo <= 1'b1;
    cyc(4);
    @(posedge clk);
    fgo <= 1'b0;
    cyc(4);
  endtask
  initial begin
    cyc(5);
    rst <= 1'b0;
    rd(`DFP_A_COAST_MODE, 32'h0000_0000);
    rd(`DFP_A_COAST_DELAY, 32'h0000_0000);
    rd(`DFP_A_FAN_SEL, 32'h0000_0002);
    rd(`DFP_A_DRV_PRE, 32'h0000_0050);
    rd(`DFP_A_MOT_PRE, 32'h0000_0050);
    rd(`DFP_A_DRV_OL, 32'h0000_0096);
    rd(`DFP_A_MOT_OL, 32'h0000_0064);
    rd(`DFP_A_IPL_EN, 32'h0000_0001);
    rd(`DFP_A_OH_EN, 32'h0000_0001);
    rd(`DFP_A_OPL_EN, 32'h0000_0000);
    rd(8'h03, 32'h0000_0000);
    wr(`DFP_A_DRV_OL, 32'h0000_00BF);
    rd(`DFP_A_DRV_OL, 32'h0000_0096);
    wr(`DFP_A_DRV_OL, 32'h0000_0078);
    wr(`DFP_A_MOT_OL, 32'h0000_0013);
    wr(`DFP_A_DRV_PRE, 32'h0000_0065);
    wr(`DFP_A_FAN_SEL, 32'h0000_0003);
    rd(`DFP_A_MOT_OL, 32'h0000_0064);
    rd(`DFP_A_DRV_PRE, 32'h0000_0050);
    rd(`DFP_A_FAN_SEL, 32'h0000_0002);
    cyc(3);
    cmp("drive limit", 32'h0000_04B0, {16'h0000, dol});
    cmp("drive prealarm", 32'h0000_03C0, {16'h0000, dpre});
    cmp("motor limit", 32'h0000_03E8, {16'h0000, mol});
    wr(`DFP_A_MOT_OL, 32'h0000_0032);
    cyc(3);
    cmp("motor limit", 32'h0000_01F4, {16'h0000, mol});
    cmp("motor prealarm", 32'h0000_0190, {16'h0000, mpre});
    @(posedge clk);
    bfreq <= 16'h01F4;
    cyc(4);
    cmp("motor limit", 32'h0000_0190, {16'h0000, mol});
    @(posedge clk);
    bfreq <= 16'h1388;
    wr(`DFP_A_COAST_DELAY, 32'h0000_0002);
    @(posedge clk);
    term <= 1'b1;
    cyc(1);
    cmp("coast", 32'h0000_0001, {31'h0, coast_stop});
    @(posedge clk);
    term <= 1'b0;
    cyc(1);
    cmp("coast", 32'h0000_0000, {31'h0, coast_stop});
    wr(`DFP_A_COAST_MODE, 32'h0000_0001);
    @(posedge clk);
    term <= 1'b1;
    n = 0;
    while (coast_stop !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    cmp("coast wait", 32'h0000_0001, {31'h0, n >= 19 && n <= 23});
    @(posedge clk);
    term <= 1'b0;
    other <= 1'b1;
    cyc(1);
    cmp("coast", 32'h0000_0001, {31'h0, coast_stop});
    @(posedge clk);
    other <= 1'b0;
    @(posedge clk);
    term <= 1'b1;
    cyc(5);
    @(posedge clk);
    term <= 1'b0;
    cyc(15);
    cmp("coast", 32'h0000_0000, {31'h0, coast_stop});
    @(posedge clk);
    search <= 1'b1;
    term <= 1'b1;
    cyc(2);
    cmp("coast", 32'h0000_0001, {31'h0, coast_stop});
    @(posedge clk);
    search <= 1'b0;
    term <= 1'b0;
    wr(`DFP_A_FAN_SEL, 32'h0000_0001);
    cyc(2);
    cmp("fan", 32'h0000_0001, {31'h0, fan_on});
    wr(`DFP_A_FAN_SEL, 32'h0000_0000);
    cyc(2);
    cmp("fan", 32'h0000_0000, {31'h0, fan_on});
    @(posedge clk);
    hot <= 1'b1;
    cyc(2);
    cmp("fan", 32'h0000_0001, {31'h0, fan_on});
    wr(`DFP_A_FAN_SEL, 32'h0000_0002);
    @(posedge clk);
    hot <= 1'b0;
    running <= 1'b1;
    cyc(2);
    cmp("fan", 32'h0000_0001, {31'h0, fan_on});
    @(posedge clk);
    hot <= 1'b1;
    running <= 1'b0;
    cyc(3);
    cmp("fan", 32'h0000_0001, {31'h0, fan_on});
    @(posedge clk);
    hot <= 1'b0;
    cyc(2);
    cmp("fan", 32'h0000_0000, {31'h0, fan_on});
    fault(12);
    rd(`DFP_A_TRIP0, 32'h0000_0000);
    wr(`DFP_A_OPL_EN, 32'h0000_0001);
    for (int i = 0; i < 22; i++) begin
      fault(i);
      rd(`DFP_A_TRIP0, {24'h0, CODES[i*8 +: 8]});
    end
    rd(`DFP_A_TRIP1, 32'h0000_0031);
    rd(`DFP_A_TRIP2, 32'h0000_002E);
    rd(`DFP_A_REC0, 32'h0000_1388);
    rd(`DFP_A_REC0 + 8'h01, 32'h0000_0115);
    rd(`DFP_A_REC0 + 8'h04, 32'h0000_0114);
    rd(`DFP_A_REC0 + 8'h08, 32'h0000_0213);
    rd(`DFP_A_CNT_OC, 32'h0000_0003);
    rd(`DFP_A_CNT_OV, 32'h0000_0001);
    rd(`DFP_A_CNT_OH, 32'h0000_0001);
    rd(`DFP_A_CNT_OL, 32'h0000_0002);
    rd(`DFP_A_IRQ_STAT, 32'h0000_0003);
    cmp("irq", 32'h0000_0000, {31'h0, irq});
    wr(`DFP_A_IRQ_MASK, 32'h0000_0001);
    cyc(1);
    cmp("irq", 32'h0000_0001, {31'h0, irq});
    wr(`DFP_A_IRQ_STAT, 32'h0000_0001);
    cyc(1);
    cmp("irq", 32'h0000_0000, {31'h0, irq});
    rd(`DFP_A_IRQ_STAT, 32'h0000_0002);
    tally_and_finish;
  end
endmodule
bind dfp_top dfp_top_assertions #(.DW(DW)) dfp_top_assertions_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .term_coast_req(term_coast_req),
  .other_coast_req(other_coast_req), .speed_search(speed_search),
  .running(running), .heatsink_hot(heatsink_hot), .rated_curr(rated_curr),
  .overvoltage_trip(overvoltage_trip), .watchdog_trip(watchdog_trip),
  .coast_stop(coast_stop), .fan_on(fan_on), .drive_ol_limit(drive_ol_limit),
  .trip_out(trip_out));
